// ---- logic/panel_pkg.sv ----
// Notes on behaviour
// - While the panel is locked no button press produces any control action.
// - A button press while locked and no light pattern is running flashes all button lights rapidly three times and does nothing else.
// - Holding the top two buttons together for 3 s while unlocked locks the panel.
// - Locking flashes all button lights and the red activity light three times rapidly.
// - Holding the top two buttons together for 3 s while locked unlocks the panel.
// - Unlocking flashes all button lights three times slowly while the activity light blinks green three times.
// - Lock and unlock requests from the host command port and the configuration software act like the gesture.
// - The reset light stays lit while the reset button is held.
// - After a 3 s hold of the reset button the reset light blinks once.
// - A confirming press that begins within 1 s of releasing the long hold restores the default configuration.
// - A successful configuration restore blinks the reset light four times.
// - A reset button already held at power-up restores the factory firmware instead of booting normally.
// - When the firmware restore completes the button lights scroll clockwise until the button is released.
package panel_pkg;

  localparam int N_BTN = 4;

  // time base
  localparam longint unsigned CLK_PERIOD_NS  = 64'd10;
  localparam longint unsigned NS_PER_MS      = 64'd1000000;
  localparam longint unsigned HOLD_MS        = 64'd3000;
  localparam longint unsigned WINDOW_MS      = 64'd1000;
  localparam longint unsigned FAST_HALF_MS   = 64'd100;
  localparam longint unsigned SLOW_HALF_MS   = 64'd400;
  localparam longint unsigned SCROLL_STEP_MS = 64'd150;

  localparam logic [31:0] HOLD_CYC   = 32'(HOLD_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [31:0] WINDOW_CYC = 32'(WINDOW_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [31:0] FAST_CYC   = 32'(FAST_HALF_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [31:0] SLOW_CYC   = 32'(SLOW_HALF_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [31:0] SCROLL_CYC = 32'(SCROLL_STEP_MS * NS_PER_MS / CLK_PERIOD_NS);

  // flash counts
  localparam logic [3:0] FLASH_PANEL   = 4'h3;
  localparam logic [3:0] FLASH_ARMED   = 4'h1;
  localparam logic [3:0] FLASH_RESTORE = 4'h4;

  // the two buttons of the lock gesture
  localparam int BTN_ON  = 0;
  localparam int BTN_OFF = 1;

  typedef enum logic [3:0] {
    S_BOOT    = 4'h0,
    S_FW      = 4'h1,
    S_SCROLL  = 4'h2,
    R_IDLE    = 4'h3,
    R_HOLD    = 4'h4,
    R_ARMED   = 4'h5,
    R_WAIT    = 4'h6,
    R_CONF    = 4'h7,
    R_RESTORE = 4'h8,
    R_BLINK   = 4'h9
  } seq_t;

  typedef enum logic [1:0] {
    P_NONE   = 2'h0,
    P_DENY   = 2'h1,
    P_LOCK   = 2'h2,
    P_UNLOCK = 2'h3
  } pat_t;

  typedef struct packed {
    seq_t             seq;
    logic             locked;
    pat_t             pat;
    logic [N_BTN-1:0] btn_prev;
    logic [N_BTN-1:0] scroll;
    logic [31:0]      step;
    logic [N_BTN-1:0] btn_led;
    logic             act_red;
    logic             act_green;
    logic             rst_led;
    logic [N_BTN-1:0] press;
    logic             cfg_req;
    logic             fw_req;
    logic             boot_done;
  } top_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        reached;
    logic        done;
  } hold_state_t;

  typedef struct packed {
    logic [4:0]  halves;
    logic [31:0] tmr;
    logic [31:0] half;
    logic        on;
  } flash_state_t;

endpackage

// ---- logic/flash_if.sv ----
`timescale 1ns/10ps
interface flash_if;
  logic        start;
  logic [3:0]  flashes;
  logic [31:0] half;
  logic        on;
  logic        busy;

  modport gen
  (
    input  start,
    input  flashes,
    input  half,
    output on,
    output busy
  );

  modport ctl
  (
    output start,
    output flashes,
    output half,
    input  on,
    input  busy
  );
endinterface

// ---- logic/hold_timer.sv ----
`timescale 1ns/10ps
module hold_timer
  import panel_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // level to time
  input  wire logic        level,
  input  wire logic [31:0] limit,
  // one-cycle pulse when the level has lasted limit cycles
  output logic             done
);

  hold_state_t s_q;
  hold_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!level)
    begin
      s_d.cnt     = 32'h0;
      s_d.reached = 1'b0;
    end
    else if (!s_q.reached)
    begin
      if (s_q.cnt >= limit - 32'h1)
      begin
        s_d.reached = 1'b1;
        s_d.done    = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;

endmodule

// ---- logic/flash_gen.sv ----
`timescale 1ns/10ps
module flash_gen
  import panel_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control side
  flash_if.gen      fl
);

  flash_state_t s_q;
  flash_state_t s_d;

  // a new start restarts the pattern, so a later pattern overrides a running one
  always_comb
  begin
    s_d = s_q;
    if (fl.start)
    begin
      s_d.halves = {fl.flashes, 1'b0};
      s_d.half   = fl.half;
      s_d.tmr    = fl.half;
      s_d.on     = 1'b1;
    end
    else if (s_q.halves != 5'h0)
    begin
      if (s_q.tmr <= 32'h1)
      begin
        s_d.halves = s_q.halves - 5'h1;
        s_d.tmr    = s_q.half;
        s_d.on     = (s_q.halves != 5'h1) && !s_q.on;
      end
      else
      begin
        s_d.tmr = s_q.tmr - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign fl.on   = s_q.on;
  assign fl.busy = (s_q.halves != 5'h0);

endmodule

// ---- logic/panel_lockout_reset_sequencer.sv ----
`timescale 1ns/10ps
module panel_lockout_reset_sequencer
  import panel_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES   = HOLD_CYC,
  parameter logic [31:0] WINDOW_CYCLES = WINDOW_CYC,
  parameter logic [31:0] FAST_CYCLES   = FAST_CYC,
  parameter logic [31:0] SLOW_CYCLES   = SLOW_CYC,
  parameter logic [31:0] SCROLL_CYCLES = SCROLL_CYC
)
(
  // clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST_N,
  // panel buttons, high while pressed, clockwise order
  input  wire logic [N_BTN-1:0] BTN,
  input  wire logic             RESET_BTN,
  // backlight wishes of the application while idle
  input  wire logic [N_BTN-1:0] LED_REQ,
  // lock requests, one-cycle pulses
  input  wire logic             HOST_LOCK,
  input  wire logic             HOST_UNLOCK,
  input  wire logic             CFG_LOCK,
  input  wire logic             CFG_UNLOCK,
  // restore engines
  input  wire logic             CFG_RESTORE_DONE,
  input  wire logic             CFG_RESTORE_OK,
  input  wire logic             FW_RESTORE_DONE,
  output logic                  CFG_RESTORE_REQ,
  output logic                  FW_RESTORE_REQ,
  output logic                  BOOT_DONE,
  // accepted button presses
  output logic [N_BTN-1:0]      BTN_PRESS,
  output logic                  LOCKED,
  // indicators
  output logic [N_BTN-1:0]      BTN_LED,
  output logic                  ACT_LED_RED,
  output logic                  ACT_LED_GREEN,
  output logic                  RESET_INDICATOR
);

  top_state_t s_q;
  top_state_t s_d;

  logic       gesture_done;
  logic       hold_done;
  logic       window_done;
  logic       operating;
  logic       gesture;

  flash_if pfl();
  flash_if rfl();

  //////////////////////////////////////////////////////////////////////////////
  // timers and flash generators

  assign gesture   = BTN[BTN_ON] && BTN[BTN_OFF];
  assign operating = (s_q.seq != S_BOOT) && (s_q.seq != S_FW) && (s_q.seq != S_SCROLL);

  hold_timer u_gesture
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .level (gesture && operating),
    .limit (HOLD_CYCLES),
    .done  (gesture_done)
  );

  hold_timer u_reset_hold
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .level (RESET_BTN && (s_q.seq == R_HOLD)),
    .limit (HOLD_CYCLES),
    .done  (hold_done)
  );

  hold_timer u_window
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .level (s_q.seq == R_WAIT),
    .limit (WINDOW_CYCLES),
    .done  (window_done)
  );

  flash_gen u_panel_flash
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .fl    (pfl.gen)
  );

  flash_gen u_reset_flash
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .fl    (rfl.gen)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [N_BTN-1:0] edges;
    logic             lock_req;
    logic             unlock_req;
    edges       = '0;
    lock_req    = 1'b0;
    unlock_req  = 1'b0;
    s_d         = s_q;
    s_d.press   = '0;
    s_d.cfg_req = 1'b0;
    s_d.fw_req  = 1'b0;
    pfl.start   = 1'b0;
    pfl.flashes = FLASH_PANEL;
    pfl.half    = FAST_CYCLES;
    rfl.start   = 1'b0;
    rfl.flashes = FLASH_ARMED;
    rfl.half    = FAST_CYCLES;

    edges        = BTN & ~s_q.btn_prev;
    s_d.btn_prev = BTN;

    // panel lockout
    if (operating)
    begin
      lock_req   = (gesture_done && !s_q.locked) || HOST_LOCK || CFG_LOCK;
      unlock_req = (gesture_done && s_q.locked) || HOST_UNLOCK || CFG_UNLOCK;
      // lock wins when both kinds of request meet in one cycle
      if (lock_req && !s_q.locked)
      begin
        s_d.locked = 1'b1;
        s_d.pat    = P_LOCK;
        pfl.start  = 1'b1;
      end
      else if (unlock_req && !lock_req && s_q.locked)
      begin
        s_d.locked = 1'b0;
        s_d.pat    = P_UNLOCK;
        pfl.half   = SLOW_CYCLES;
        pfl.start  = 1'b1;
      end
      else if (s_q.locked && (|edges) && !pfl.busy)
      begin
        // a running pattern is not restarted, so a held gesture cannot stutter it
        s_d.pat   = P_DENY;
        pfl.start = 1'b1;
      end
      if (!s_q.locked)
        s_d.press = edges;
    end

    // reset button sequences
    unique case (s_q.seq)
      S_BOOT:
      begin
        if (RESET_BTN)
        begin
          s_d.seq    = S_FW;
          s_d.fw_req = 1'b1;
        end
        else
        begin
          s_d.seq       = R_IDLE;
          s_d.boot_done = 1'b1;
        end
      end
      S_FW:
      begin
        if (FW_RESTORE_DONE)
        begin
          s_d.seq    = S_SCROLL;
          s_d.scroll = {{(N_BTN-1){1'b0}}, 1'b1};
          s_d.step   = 32'h0;
        end
      end
      S_SCROLL:
      begin
        if (!RESET_BTN)
        begin
          s_d.seq       = R_IDLE;
          s_d.scroll    = '0;
          s_d.boot_done = 1'b1;
        end
        else if (s_q.step >= SCROLL_CYCLES - 32'h1)
        begin
          s_d.step   = 32'h0;
          s_d.scroll = {s_q.scroll[N_BTN-2:0], s_q.scroll[N_BTN-1]};
        end
        else
        begin
          s_d.step = s_q.step + 32'h1;
        end
      end
      R_IDLE:
      begin
        if (RESET_BTN)
          s_d.seq = R_HOLD;
      end
      R_HOLD:
      begin
        if (!RESET_BTN)
          s_d.seq = R_IDLE;
        else if (hold_done)
        begin
          s_d.seq   = R_ARMED;
          rfl.start = 1'b1;
        end
      end
      R_ARMED:
      begin
        if (!RESET_BTN)
          s_d.seq = R_WAIT;
      end
      R_WAIT:
      begin
        if (RESET_BTN)
          s_d.seq = R_CONF;
        else if (window_done)
          s_d.seq = R_IDLE;
      end
      R_CONF:
      begin
        // restore starts on the release, so a press that is held on is not a confirm yet
        if (!RESET_BTN)
        begin
          s_d.seq     = R_RESTORE;
          s_d.cfg_req = 1'b1;
        end
      end
      R_RESTORE:
      begin
        if (CFG_RESTORE_DONE)
        begin
          if (CFG_RESTORE_OK)
          begin
            s_d.seq     = R_BLINK;
            rfl.flashes = FLASH_RESTORE;
            rfl.start   = 1'b1;
          end
          else
          begin
            s_d.seq = R_IDLE;
          end
        end
      end
      R_BLINK:
      begin
        if (!rfl.busy)
          s_d.seq = R_IDLE;
      end
      default:
      begin
        s_d.seq = R_IDLE;
      end
    endcase

    // indicators
    if (s_q.seq == S_SCROLL)
      s_d.btn_led = s_q.scroll;
    else if (pfl.busy)
      s_d.btn_led = {N_BTN{pfl.on}};
    else
      s_d.btn_led = LED_REQ;
    s_d.act_red   = pfl.on && (s_q.pat == P_LOCK);
    s_d.act_green = pfl.on && (s_q.pat == P_UNLOCK);
    // a blink while held shows as a short dark gap in the steady light
    s_d.rst_led   = RESET_BTN ^ rfl.on;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_q     <= '0;
      s_q.seq <= S_BOOT;
      s_q.pat <= P_NONE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign CFG_RESTORE_REQ = s_q.cfg_req;
  assign FW_RESTORE_REQ  = s_q.fw_req;
  assign BOOT_DONE       = s_q.boot_done;
  assign BTN_PRESS       = s_q.press;
  assign LOCKED          = s_q.locked;
  assign BTN_LED         = s_q.btn_led;
  assign ACT_LED_RED     = s_q.act_red;
  assign ACT_LED_GREEN   = s_q.act_green;
  assign RESET_INDICATOR       = s_q.rst_led;

endmodule

// ---- tb/panel_props.sv ----
`timescale 1ns/10ps
module panel_props
  import panel_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = HOLD_CYC
)
(
  // clock and reset
  input wire logic             CLK_SYS,
  input wire logic             RST_N,
  // inputs of the sequencer
  input wire logic [N_BTN-1:0] BTN,
  input wire logic             RESET_BTN,
  input wire logic             HOST_LOCK,
  input wire logic             HOST_UNLOCK,
  input wire logic             CFG_LOCK,
  input wire logic             CFG_UNLOCK,
  // outputs of the sequencer
  input wire logic             CFG_RESTORE_REQ,
  input wire logic             FW_RESTORE_REQ,
  input wire logic             BOOT_DONE,
  input wire logic [N_BTN-1:0] BTN_PRESS,
  input wire logic             LOCKED,
  input wire logic [N_BTN-1:0] BTN_LED,
  input wire logic             ACT_LED_RED,
  input wire logic             ACT_LED_GREEN,
  input wire logic             RESET_INDICATOR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////////
  // run lengths of the reset hold and of the lock gesture
  logic [31:0] hcnt_q;
  logic [31:0] gcnt_q;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      hcnt_q <= '0;
      gcnt_q <= '0;
    end
    else
    begin
      hcnt_q <= (RESET_BTN && BOOT_DONE) ? hcnt_q + 32'h1 : '0;
      gcnt_q <= (BTN[1:0] == 2'h3) ? gcnt_q + 32'h1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  press_edge_a: assert property (BOOT_DONE && $past(BOOT_DONE) && !LOCKED && $rose(BTN[2])
    |=> BTN_PRESS[2] ##1 !BTN_PRESS[2]) else $error("press edge not passed once");
  locked_mute_a: assert property (LOCKED && $past(LOCKED) |-> BTN_PRESS == 4'h0)
    else $error("press passed while locked");
  toggle_cause_a: assert property ($changed(LOCKED) |-> gcnt_q >= HOLD_CYCLES - 32'h1
    || $past(HOST_LOCK || HOST_UNLOCK || CFG_LOCK || CFG_UNLOCK)) else $error("lock toggled without cause");
  lock_flash_a: assert property ($rose(LOCKED) |-> ##[0:2] (BTN_LED == 4'hf && ACT_LED_RED))
    else $error("no red flash on lock");
  unlock_flash_a: assert property ($fell(LOCKED) |-> ##[0:2] (BTN_LED == 4'hf && ACT_LED_GREEN))
    else $error("no green flash on unlock");
  remote_lock_a: assert property ((HOST_LOCK || CFG_LOCK) && BOOT_DONE |=> LOCKED)
    else $error("lock request lost");
  reset_lit_a: assert property (hcnt_q >= 32'h3 && hcnt_q <= HOLD_CYCLES - 32'h2 |-> RESET_INDICATOR)
    else $error("reset light dark while held");
  cfg_req_a: assert property (CFG_RESTORE_REQ |-> !RESET_BTN
    && ($past(RESET_BTN, 2) || $past(RESET_BTN, 3) || $past(RESET_BTN, 4))) else $error("restore without release");
  fw_req_a: assert property (FW_RESTORE_REQ |-> !BOOT_DONE && RESET_BTN)
    else $error("firmware restore out of boot");

  lock_seen_c: cover property ($rose(LOCKED));
  unlock_seen_c: cover property ($fell(LOCKED));
  cfg_seen_c: cover property (CFG_RESTORE_REQ);
  fw_seen_c: cover property (FW_RESTORE_REQ);
endmodule

bind panel_lockout_reset_sequencer panel_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_panel_props
(
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .BTN(BTN), .RESET_BTN(RESET_BTN), .HOST_LOCK(HOST_LOCK),
  .HOST_UNLOCK(HOST_UNLOCK), .CFG_LOCK(CFG_LOCK), .CFG_UNLOCK(CFG_UNLOCK), .CFG_RESTORE_REQ(CFG_RESTORE_REQ),
  .FW_RESTORE_REQ(FW_RESTORE_REQ), .BOOT_DONE(BOOT_DONE), .BTN_PRESS(BTN_PRESS), .LOCKED(LOCKED),
  .BTN_LED(BTN_LED), .ACT_LED_RED(ACT_LED_RED), .ACT_LED_GREEN(ACT_LED_GREEN), .RESET_INDICATOR(RESET_INDICATOR)
);

// ---- tb/panel_model.sv ----
`timescale 1ns/10ps
module panel_model
  import panel_pkg::*;
(
  // clock and bench side
  input  wire logic             clk,
  input  wire logic             clr,
  input  wire logic [N_BTN-1:0] push,
  input  wire logic             push_rst,
  // device side
  output logic [N_BTN-1:0]      btn,
  output logic                  reset_btn,
  input  wire logic [N_BTN-1:0] btn_press,
  input  wire logic [N_BTN-1:0] btn_led,
  input  wire logic             act_red,
  input  wire logic             act_green,
  input  wire logic             reset_indicator,
  // what the panel saw
  output logic [7:0]            n_flash,
  output logic [7:0]            n_red,
  output logic [7:0]            n_green,
  output logic [7:0]            n_rst,
  output logic [7:0]            n_press
);
  logic [3:0] prev_q;

  // contacts follow the finger directly, no bounce modelled
  assign btn       = push;
  assign reset_btn = push_rst;

  // lamps counted by their turn-on edges
  always @(posedge clk)
  begin
    if (clr)
    begin
      {n_flash, n_red, n_green, n_rst, n_press} = '0;
    end
    else
    begin
      n_flash += 8'((btn_led == 4'hf) && !prev_q[0]);
      n_red   += 8'(act_red && !prev_q[1]);
      n_green += 8'(act_green && !prev_q[2]);
      n_rst   += 8'(reset_indicator && !prev_q[3]);
      n_press += 8'(btn_press != 4'h0);
    end
    prev_q = {reset_indicator, act_green, act_red, btn_led == 4'hf};
  end
endmodule

// ---- tb/tb_panel_lockout_reset_sequencer.sv ----
`timescale 1ns/10ps
module tb_panel_lockout_reset_sequencer
  import panel_pkg::*;
;
  localparam int HOLD = 32'h28;
  localparam int WIN  = 32'h1e;

  logic       clk = 1'b0, rst_n = 1'b0, clr = 1'b0, push_rst = 1'b0;
  logic       cr_done = 1'b0, cr_ok = 1'b0, fw_done = 1'b0;
  logic [3:0] push = 4'h0, req4 = 4'h0, btn, press, led;
  logic       reset_btn, cfg_req, fw_req, boot_done, locked, red, green, rled;
  logic [7:0] n_flash, n_red, n_green, n_rst, n_press;
  logic [2:0] watch;
  int         n_mismatch = 0, checks_done = 0, n_req = 0;

  assign watch = {fw_req, cfg_req, locked};
  always #5 clk = ~clk;
  always @(posedge clk) if (cfg_req === 1'b1) n_req++;

  panel_lockout_reset_sequencer #(.HOLD_CYCLES(HOLD), .WINDOW_CYCLES(WIN), .FAST_CYCLES(32'h3),
    .SLOW_CYCLES(32'h6), .SCROLL_CYCLES(32'h4)) u_panel_lockout_reset_sequencer
  (
    .CLK_SYS(clk), .RST_N(rst_n), .BTN(btn), .RESET_BTN(reset_btn), .LED_REQ(4'h0),
    .HOST_LOCK(req4[3]), .HOST_UNLOCK(req4[2]), .CFG_LOCK(req4[1]), .CFG_UNLOCK(req4[0]),
    .CFG_RESTORE_DONE(cr_done), .CFG_RESTORE_OK(cr_ok), .FW_RESTORE_DONE(fw_done),
    .CFG_RESTORE_REQ(cfg_req), .FW_RESTORE_REQ(fw_req), .BOOT_DONE(boot_done), .BTN_PRESS(press),
    .LOCKED(locked), .BTN_LED(led), .ACT_LED_RED(red), .ACT_LED_GREEN(green), .RESET_INDICATOR(rled)
  );

  panel_model u_panel_model
  (
    .clk(clk), .clr(clr), .push(push), .push_rst(push_rst), .btn(btn), .reset_btn(reset_btn),
    .btn_press(press), .btn_led(led), .act_red(red), .act_green(green), .reset_indicator(rled),
    .n_flash(n_flash), .n_red(n_red), .n_green(n_green), .n_rst(n_rst), .n_press(n_press)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task tick(int n);
    repeat (n) @(negedge clk);
  endtask

  task wait_for(int sel, logic v, int lim);
    for (int k = 0; k < lim && watch[sel] !== v; k++) tick(1);
    if (watch[sel] !== v)
    begin
      check("wait bound", watch[sel], v);
      give_verdict;
    end
  endtask

  task clear;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
  endtask

  task do_reset(logic held);
    rst_n = 1'b0;
    push_rst = held;
    tick(20);
    rst_n = 1'b1;
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_press;
    check("boot", boot_done, 1'b1);
    clear;
    push = 4'h4;
    tick(3);
    push = 4'h0;
    tick(2);
    check("press count", n_press, 8'h1);
  endtask

  task t_lock;
    push = 4'h3;
    tick(20);
    push = 4'h0;
    tick(2);
    check("short gesture", locked, 1'b0);
    clear;
    push = 4'h3;
    wait_for(0, 1'b1, HOLD + 20);
    tick(3);
    push = 4'h0;
    tick(50);
    check("red flashes", n_red, 8'h3);
    check("lock flashes", n_flash, 8'h3);
  endtask

  task t_deny;
    clear;
    push = 4'h8;
    tick(2);
    push = 4'h0;
    tick(30);
    check("locked press", n_press, 8'h0);
    check("deny flashes", n_flash, 8'h3);
    check("still locked", locked, 1'b1);
  endtask

  task t_unlock;
    clear;
    push = 4'h3;
    wait_for(0, 1'b0, HOLD + 20);
    tick(3);
    push = 4'h0;
    tick(60);
    check("green blinks", n_green, 8'h3);
    check("no red", n_red, 8'h0);
  endtask

  task t_remote;
    for (int i = 0; i < 4; i++)
    begin
      req4 = 4'h8 >> i;
      tick(1);
      req4 = 4'h0;
      tick(40);
      check("remote lock", locked, !i[0]);
    end
  endtask

  task t_cfg;
    push_rst = 1'b1;
    tick(5);
    check("reset lit", rled, 1'b1);
    clear;
    tick(HOLD + 10);
    check("armed blink", n_rst, 8'h1);
    push_rst = 1'b0;
    tick(5);
    push_rst = 1'b1;
    tick(3);
    push_rst = 1'b0;
    wait_for(1, 1'b1, 10);
    clear;
    {cr_done, cr_ok} = 2'h3;
    tick(1);
    cr_done = 1'b0;
    tick(40);
    check("restore blinks", n_rst, 8'h4);
  endtask

  task t_abandon;
    int base;
    base = n_req;
    push_rst = 1'b1;
    tick(20);
    push_rst = 1'b0;
    tick(WIN + 10);
    check("short hold", n_req, base);
    push_rst = 1'b1;
    tick(HOLD + 10);
    push_rst = 1'b0;
    tick(WIN + 20);
    push_rst = 1'b1;
    tick(3);
    push_rst = 1'b0;
    tick(10);
    check("late confirm", n_req, base);
  endtask

  task t_fail;
    push_rst = 1'b1;
    tick(HOLD + 10);
    push_rst = 1'b0;
    tick(5);
    push_rst = 1'b1;
    tick(3);
    push_rst = 1'b0;
    wait_for(1, 1'b1, 10);
    clear;
    {cr_done, cr_ok} = 2'h2;
    tick(1);
    cr_done = 1'b0;
    tick(40);
    check("failed restore blinks", n_rst, 8'h0);
  endtask

  task t_fw;
    logic [3:0] p;
    do_reset(1'b1);
    wait_for(2, 1'b1, 10);
    check("held boot", boot_done, 1'b0);
    fw_done = 1'b1;
    tick(1);
    fw_done = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      p = led;
      for (int k = 0; k < 10 && led === p; k++) tick(1);
      check("scroll", led, 4'h1 << (i % 4));
    end
    push_rst = 1'b0;
    tick(3);
    check("boot after scroll", boot_done, 1'b1);
  endtask

  initial
  begin
    do_reset(1'b0);
    tick(3);
    t_press;
    t_lock;
    t_deny;
    t_unlock;
    t_remote;
    t_cfg;
    t_abandon;
    t_fail;
    t_fw;
    give_verdict;
  end
endmodule
